/* rtl/edge_shaper_defines.svh */
`ifndef EDGE_SHAPER_DEFINES_SVH
`define EDGE_SHAPER_DEFINES_SVH
// register indices; byte address is four times the index
`define IDX_SHAPE_SELECT 8'h51
`define IDX_TIMING_INDEX 8'h52
`define IDX_COUNT_STRETCH 8'h53
`define IDX_CARRIER_FLOOR 8'h54
`define IDX_CONTROL 8'h58
`define IDX_STATUS 8'h59
`define RST_SHAPE_SELECT 8'h11
`define RST_TIMING_INDEX 8'h00
`define RST_COUNT_STRETCH 8'h04
`define RST_CARRIER_FLOOR 8'h00
// field positions
`define FALL_CODE_HI 7
`define FALL_CODE_LO 4
`define RISE_CODE_HI 3
`define RISE_CODE_LO 0
`define FALL_SET_HI 6
`define FALL_SET_LO 4
`define RISE_SET_HI 2
`define RISE_SET_LO 0
`define STRETCH_BIT 7
`define COUNT_HI 4
`define COUNT_LO 0
`define CTRL_START_FALL 0
`define CTRL_START_RISE 1
`endif

/* rtl/edge_shaper_pkg.sv */
package edge_shaper_pkg;
	typedef enum logic [3:0] {
		CODE_LIN1     = 4'h1,
		CODE_LIN2     = 4'h2,
		CODE_LIN3     = 4'h3,
		CODE_LUT      = 4'h4,
		CODE_LUT_CORR = 4'h5,
		CODE_LUT_ADPT = 4'h6
	} shape_code_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b10
	} seq_state_e;
endpackage : edge_shaper_pkg

/* rtl/edge_amp_calc.sv */
`timescale 1ns/1ps
// amplitude of one transition step from the edge code and position
module edge_amp_calc (
	input  wire logic [3:0] code,
	input  wire logic [2:0] setting,
	input  wire logic [4:0] step,
	input  wire logic [4:0] count,
	input  wire logic [7:0] floor_lvl,
	input  wire logic [7:0] supply,
	output logic      [7:0] amp,
	output logic            reserved
);
	logic [15:0] lin;
	logic [15:0] adj;
	logic [7:0]  frac;
	logic [7:0]  tbl;
	logic [7:0]  sq;
	logic [7:0]  span;
	// fraction of the way through the edge, 0..255
	always_comb begin
		span = 8'hFF - floor_lvl;
		frac = (count == 5'h00) ? 8'hFF :
			8'((16'(step) * 16'h00FF) / 16'(count));
		// firmware styles: bend the ramp into one or two segments
		unique case (code)
			edge_shaper_pkg::CODE_LIN2: frac = (frac < 8'h80) ?
				8'(frac >> 1) : 8'(9'(frac) + 9'(frac >> 1) - 9'h07F);
			edge_shaper_pkg::CODE_LIN3: frac = (frac < 8'h55) ?
				8'(frac >> 2) : frac;
			default: frac = frac;
		endcase
		// table index selects one of four curvature tables; setting
		// adds a slope offset for firmware styles
		sq  = 8'((16'(frac) * 16'(frac)) / 16'h00FF);
		tbl = 8'(frac >> setting[1:0]) | 8'(frac << setting[2]);
		// tables blend a square-law curve toward the straight ramp, so
		// every table still starts at zero and ends at full
		if (code >= 4'h4)
			tbl = 8'(sq + 8'((16'(frac - sq) * 16'(setting[1:0])) /
				16'h0003));
		// divide by 255, not 256, so a full table value reaches 0xFF
		lin = 16'(floor_lvl) + ((16'(tbl) * 16'(span)) / 16'h00FF);
		adj = lin;
		// supply adaptation scales by measured supply
		if (code == 4'h5)
			adj = (lin * 16'(supply)) >> 7;
		else if (code == 4'h6)
			adj = (lin * 16'({1'b1, supply[7:1]})) >> 7;
		amp = (adj > 16'h00FF) ? 8'hFF : adj[7:0];
		reserved = (code == 4'h0) || (code > 4'h6);
	end
endmodule : edge_amp_calc

/* rtl/edge_step_timer.sv */
`timescale 1ns/1ps
// one tick per transition state: every carrier cycle or every second
module edge_step_timer (
	input  wire logic CLK,
	input  wire logic RST_N,
	input  wire logic carrier_tick,
	input  wire logic run,
	input  wire logic stretch,
	output logic      step_pulse
);
	logic half_reg;
	// stretch doubles the state length for both edges alike
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			half_reg <= 1'b0;
		else if (!run)
			half_reg <= 1'b0;
		else if (carrier_tick)
			half_reg <= stretch ? ~half_reg : 1'b0;
	end
	assign step_pulse = run && carrier_tick && (!stretch || half_reg);
endmodule : edge_step_timer

/* rtl/edge_shaper.sv */
`timescale 1ns/1ps
`include "edge_shaper_defines.svh"
module edge_shaper (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [9:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [9:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        CARRIER_TICK,
	input  wire logic [7:0]  POWER_AMP_SUPPLY,
	output logic [7:0]       CARRIER_AMP,
	output logic             EDGE_BUSY
);
	logic [7:0] shape_reg;
	logic [7:0] timing_reg;
	logic [7:0] length_reg;
	logic [7:0] floor_reg;
	logic [9:0] awaddr_reg;
	logic       aw_have_reg;
	logic [7:0] wdata_reg;
	logic       w_have_reg;
	logic       wstrb_reg;
	logic       bvalid_reg;
	logic [1:0] bresp_reg;
	logic       rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic       do_write;
	logic [7:0] widx;
	logic [7:0] ridx;
	logic       wmapped;
	edge_shaper_pkg::seq_state_e state_reg;
	logic       falling_reg;
	logic [4:0] step_reg;
	logic [7:0] amp_reg;
	logic       rsvd_flag_reg;
	logic       step_pulse;
	logic [3:0] cur_code;
	logic [2:0] cur_set;
	logic [7:0] amp_calc;
	logic       code_rsvd;
	logic       start_fall;
	logic       start_rise;
	logic [4:0] state_count;
	logic [4:0] calc_step;
	logic [4:0] calc_count;

	// write channel: address and data taken in either order
	assign AWREADY = !aw_have_reg && !bvalid_reg;
	assign WREADY  = !w_have_reg && !bvalid_reg;
	assign do_write = aw_have_reg && w_have_reg;
	assign widx = awaddr_reg[9:2];
	assign wmapped = (widx >= `IDX_SHAPE_SELECT &&
		widx <= `IDX_CARRIER_FLOOR) || widx == `IDX_CONTROL;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_have_reg <= 1'b0;
			awaddr_reg  <= 10'h000;
		end else if (AWVALID && AWREADY) begin
			aw_have_reg <= 1'b1;
			awaddr_reg  <= AWADDR;
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			w_have_reg <= 1'b0;
			wdata_reg  <= 8'h00;
			wstrb_reg  <= 1'b0;
		end else if (WVALID && WREADY) begin
			w_have_reg <= 1'b1;
			wdata_reg  <= WDATA[7:0];
			wstrb_reg  <= WSTRB[0];
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end
	end
	// response follows both; unmapped addresses answer SLVERR
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= 2'b00;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wmapped ? 2'b00 : 2'b10;
		end else if (BREADY) begin
			bvalid_reg <= 1'b0;
		end
	end
	assign BVALID = bvalid_reg;
	assign BRESP  = bresp_reg;

	// register store; reserved bits are kept as written
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			shape_reg  <= `RST_SHAPE_SELECT;
			timing_reg <= `RST_TIMING_INDEX;
			length_reg <= `RST_COUNT_STRETCH;
			floor_reg  <= `RST_CARRIER_FLOOR;
		end else if (do_write && wstrb_reg) begin
			case (widx)
				`IDX_SHAPE_SELECT:  shape_reg  <= wdata_reg;
				`IDX_TIMING_INDEX:  timing_reg <= wdata_reg;
				`IDX_COUNT_STRETCH: length_reg <= wdata_reg;
				`IDX_CARRIER_FLOOR: floor_reg  <= wdata_reg;
				default: ;
			endcase
		end
	end
	// control writes are one-cycle start strobes
	assign start_fall = do_write && wstrb_reg && widx == `IDX_CONTROL &&
		wdata_reg[`CTRL_START_FALL];
	assign start_rise = do_write && wstrb_reg && widx == `IDX_CONTROL &&
		wdata_reg[`CTRL_START_RISE];

	// read channel: one cycle to answer
	assign ARREADY = !rvalid_reg;
	assign ridx = ARADDR[9:2];
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= 2'b00;
		end else if (ARVALID && ARREADY) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= 2'b00;
			case (ridx)
				`IDX_SHAPE_SELECT:  rdata_reg <= {24'h0, shape_reg};
				`IDX_TIMING_INDEX:  rdata_reg <= {24'h0, timing_reg};
				`IDX_COUNT_STRETCH: rdata_reg <= {24'h0, length_reg};
				`IDX_CARRIER_FLOOR: rdata_reg <= {24'h0, floor_reg};
				`IDX_CONTROL:       rdata_reg <= 32'h0000_0000;
				`IDX_STATUS: rdata_reg <= {14'h0, rsvd_flag_reg,
					falling_reg, amp_reg, 3'h0, step_reg};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= 2'b10;
				end
			endcase
		end else if (RREADY) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign RVALID = rvalid_reg;
	assign RDATA  = rdata_reg;
	assign RRESP  = rresp_reg;

	// per-edge code and setting; both edges share count and stretch
	always_comb begin
		if (falling_reg) begin
			cur_code = shape_reg[`FALL_CODE_HI:`FALL_CODE_LO];
			cur_set  = timing_reg[`FALL_SET_HI:`FALL_SET_LO];
		end else begin
			cur_code = shape_reg[`RISE_CODE_HI:`RISE_CODE_LO];
			cur_set  = timing_reg[`RISE_SET_HI:`RISE_SET_LO];
		end
	end

	// falling edges walk the curve backwards; a single-state falling edge
	// gets a denominator of one so its only state lands on the floor,
	// where a single rising state lands on full carrier
	assign state_count = length_reg[`COUNT_HI:`COUNT_LO];
	assign calc_step = falling_reg ? 5'(state_count - step_reg) : step_reg;
	assign calc_count = (falling_reg && state_count == 5'h00) ?
		5'h01 : state_count;

	edge_amp_calc edge_amp_calc_i (
		.code      (cur_code),
		.setting   (cur_set),
		.step      (calc_step),
		.count     (calc_count),
		.floor_lvl (floor_reg),
		.supply    (POWER_AMP_SUPPLY),
		.amp       (amp_calc),
		.reserved  (code_rsvd)
	);

	edge_step_timer edge_step_timer_i (
		.CLK          (CLK),
		.RST_N        (RST_N),
		.carrier_tick (CARRIER_TICK),
		.run          (state_reg == edge_shaper_pkg::ST_RUN),
		.stretch      (length_reg[`STRETCH_BIT]),
		.step_pulse   (step_pulse)
	);

	// edge sequencer: counts states, reserved codes hold the level
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg   <= edge_shaper_pkg::ST_IDLE;
			falling_reg <= 1'b0;
			step_reg    <= 5'h00;
		end else begin
			case (state_reg)
				edge_shaper_pkg::ST_IDLE, edge_shaper_pkg::ST_DONE: begin
					if (start_fall || start_rise) begin
						state_reg   <= edge_shaper_pkg::ST_RUN;
						falling_reg <= start_fall;
						step_reg    <= 5'h00;
					end else begin
						state_reg <= edge_shaper_pkg::ST_IDLE;
					end
				end
				edge_shaper_pkg::ST_RUN: begin
					if (step_pulse) begin
						if (step_reg >= length_reg[`COUNT_HI:`COUNT_LO])
							state_reg <= edge_shaper_pkg::ST_DONE;
						else
							step_reg <= step_reg + 5'h01;
					end
				end
				default: state_reg <= edge_shaper_pkg::ST_IDLE;
			endcase
		end
	end

	// amplitude output; reserved styles leave it unchanged
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			amp_reg       <= 8'hFF;
			rsvd_flag_reg <= 1'b0;
		end else if (state_reg == edge_shaper_pkg::ST_RUN && step_pulse) begin
			rsvd_flag_reg <= code_rsvd;
			if (!code_rsvd)
				amp_reg <= amp_calc;
		end
	end
	assign CARRIER_AMP = amp_reg;
	assign EDGE_BUSY   = (state_reg == edge_shaper_pkg::ST_RUN);

	// checks
	bresp_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
		do_write |=> BVALID) else $error("no write response");
	busy_steps_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(EDGE_BUSY && !step_pulse) |=> $stable(step_reg))
		else $error("step moved without tick");
	stretch_pair_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(step_pulse && length_reg[`STRETCH_BIT] && $stable(length_reg))
		|-> !$past(step_pulse)) else $error("stretch ignored");
	count_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
		EDGE_BUSY |-> step_reg <= length_reg[`COUNT_HI:`COUNT_LO])
		else $error("count overrun");
	rsvd_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(EDGE_BUSY && step_pulse && code_rsvd) |=> $stable(CARRIER_AMP))
		else $error("reserved code moved amp");
	floor_min_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(EDGE_BUSY && step_pulse && !code_rsvd && cur_code == 4'h4)
		|=> CARRIER_AMP >= floor_reg) else $error("below floor");
	fall_code_a: assert property (@(posedge CLK) disable iff (!RST_N)
		falling_reg |-> cur_code == shape_reg[7:4])
		else $error("falling code wrong");
	read_one_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(ARVALID && ARREADY) |=> RVALID) else $error("no read data");
	// a start from idle must show up as busy on the next cycle
	start_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
		((start_fall || start_rise) && !EDGE_BUSY) |=> EDGE_BUSY)
		else $error("start lost");
	// end points: falling settles on the floor, rising on full carrier
	fall_floor_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(step_pulse && falling_reg && step_reg == state_count &&
		cur_code >= 4'h1 && cur_code <= 4'h4) |=> CARRIER_AMP == floor_reg)
		else $error("fall end off floor");
	rise_full_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(step_pulse && !falling_reg && step_reg == state_count &&
		cur_code >= 4'h1 && cur_code <= 4'h4) |=> CARRIER_AMP == 8'hFF)
		else $error("rise end short of full");
	// nominal supply reading must leave the corrected table at unit gain
	supply_unit_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(step_pulse && !falling_reg && step_reg == state_count &&
		cur_code == 4'h5 && POWER_AMP_SUPPLY == 8'h80)
		|=> CARRIER_AMP == 8'hFF) else $error("supply gain off");
	// outside an edge the carrier level stays put
	idle_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!EDGE_BUSY |=> $stable(CARRIER_AMP)) else $error("amp moved idle");
	// a write with its byte lane off changes no register
	lane_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(do_write && !wstrb_reg) |=> ($stable(shape_reg) &&
		$stable(timing_reg) && $stable(length_reg) && $stable(floor_reg)))
		else $error("masked write landed");
	cover_fall_c: cover property (@(posedge CLK) start_fall);
	cover_stretch_c: cover property (@(posedge CLK)
		step_pulse && length_reg[`STRETCH_BIT]);
	cover_rsvd_c: cover property (@(posedge CLK) step_pulse && code_rsvd);
	cover_rise_c: cover property (@(posedge CLK) start_rise);
	cover_done_c: cover property (@(posedge CLK)
		state_reg == edge_shaper_pkg::ST_DONE);
endmodule : edge_shaper

/* testbench/edge_shaper_test.sv */
`timescale 1ns/1ps
`include "edge_shaper_defines.svh"
module edge_shaper_test;
	typedef struct {
		logic [7:0] idx;
		logic [7:0] d;
		logic [7:0] exp;
	} row_s;
	logic        CLK = 1'b0;
	logic        RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, EDGE_BUSY;
	logic        CARRIER_TICK = 1'b0;
	logic [9:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rdat;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, rsp;
	logic [1:0]  tick_cnt = 2'h0;
	logic [7:0]  POWER_AMP_SUPPLY, CARRIER_AMP;
	int          num_errors = 0;
	int          compares = 0;
	int          ticks;
	row_s        rows [5];
	edge_shaper edge_shaper_i (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .CARRIER_TICK(CARRIER_TICK),
		.POWER_AMP_SUPPLY(POWER_AMP_SUPPLY), .CARRIER_AMP(CARRIER_AMP),
		.EDGE_BUSY(EDGE_BUSY));
	always #5 CLK = ~CLK;
	// carrier pulse every fourth clock, slow enough to see each state
	always @(posedge CLK) begin
		tick_cnt <= tick_cnt + 2'h1;
		CARRIER_TICK <= (tick_cnt == 2'h3);
	end
	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, exp, input string msg);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, msg, seen, exp);
		end
	endtask : check
	// handshakes are judged at the falling edge, where inputs already hold
	// what the next rising edge will sample, so no race with the design
	task automatic wr(input logic [7:0] idx, d, input logic [3:0] s);
		logic aok, wok, bok;
		int i;
		@(posedge CLK);
		AWADDR <= {idx, 2'b00};
		WDATA <= {24'h000000, d};
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge CLK);
			aok = AWVALID && AWREADY;
			wok = WVALID && WREADY;
			bok = BVALID;
			rsp = BRESP;
			@(posedge CLK);
			if (aok) AWVALID <= 1'b0;
			if (wok) WVALID <= 1'b0;
			if (bok) begin
				BREADY <= 1'b0;
				break;
			end
		end
		if (i == 50) begin
			num_errors++;
			stop_test();
		end
	endtask : wr
	task automatic rd(input logic [7:0] idx);
		logic aok, rok;
		int i;
		@(posedge CLK);
		ARADDR <= {idx, 2'b00};
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge CLK);
			aok = ARVALID && ARREADY;
			rok = RVALID;
			rdat = RDATA;
			rsp = RRESP;
			@(posedge CLK);
			if (aok) ARVALID <= 1'b0;
			if (rok) begin
				RREADY <= 1'b0;
				break;
			end
		end
		if (i == 50) begin
			num_errors++;
			stop_test();
		end
	endtask : rd
	// start one edge and count carrier pulses seen while it is busy
	task automatic run_edge(input logic [7:0] ctl);
		logic seen;
		int i;
		ticks = 0;
		seen = 1'b0;
		fork
			wr(8'h58, ctl, 4'hF);
			for (i = 0; i < 2000; i++) begin
				@(negedge CLK);
				if (EDGE_BUSY === 1'b1) begin
					seen = 1'b1;
					if (CARRIER_TICK) ticks++;
				end else if (seen) break;
			end
		join
		if (i == 2000) begin
			num_errors++;
			stop_test();
		end
	endtask : run_edge
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		{AWADDR, ARADDR, WDATA, WSTRB} = 56'h0;
		POWER_AMP_SUPPLY = 8'h80;
		RST_N = 1'b0;
		rows = '{'{8'h51, 8'h23, 8'h23}, '{8'h52, 8'h35, 8'h35},
			'{8'h53, 8'h9F, 8'h9F}, '{8'h54, 8'hFF, 8'hFF},
			'{8'h54, 8'h00, 8'h00}};
		repeat (20) @(posedge CLK);
		check(CARRIER_AMP, 8'hFF, "amp in reset");
		RST_N <= 1'b1;
		rd(8'h51);
		check(rdat, `RST_SHAPE_SELECT, "shape reset");
		rd(8'h53);
		check(rdat, `RST_COUNT_STRETCH, "count reset");
		// plain register traffic: write, then read back
		foreach (rows[k]) begin
			wr(rows[k].idx, rows[k].d, 4'hF);
			check(rsp, 2'b00, "write resp");
			rd(rows[k].idx);
			check(rsp, 2'b00, "read resp");
			check(rdat, {24'h0, rows[k].exp}, "readback");
		end
		// every style code on both edges, three plus one states each
		wr(8'h52, 8'h00, 4'hF);
		wr(8'h53, 8'h03, 4'hF);
		wr(8'h54, 8'h40, 4'hF);
		for (int c = 1; c < 7; c++) begin
			wr(8'h51, {c[3:0], c[3:0]}, 4'hF);
			run_edge(8'h01);
			check(ticks, 4, "fall states");
			if (c < 6) check(CARRIER_AMP, 8'h40, "fall end");
			run_edge(8'h02);
			check(ticks, 4, "rise states");
			if (c < 6) check(CARRIER_AMP, 8'hFF, "rise end");
		end
		// half the nominal supply halves the corrected table output
		wr(8'h51, 8'h55, 4'hF);
		POWER_AMP_SUPPLY <= 8'h40;
		run_edge(8'h02);
		check(CARRIER_AMP, 8'h7F, "half supply");
		@(posedge CLK);
		POWER_AMP_SUPPLY <= 8'h80;
		// stretch doubles both edges; mixed styles per edge
		wr(8'h51, 8'h13, 4'hF);
		wr(8'h53, 8'h82, 4'hF);
		run_edge(8'h01);
		check(ticks, 6, "fall stretched");
		run_edge(8'h02);
		check(ticks, 6, "rise stretched");
		// single state edge down to no carrier at all
		wr(8'h53, 8'h00, 4'hF);
		wr(8'h54, 8'h00, 4'hF);
		run_edge(8'h01);
		check(ticks, 1, "one state");
		check(CARRIER_AMP, 8'h00, "zero floor");
		run_edge(8'h02);
		// reserved falling code must leave the carrier where it is
		wr(8'h51, 8'h71, 4'hF);
		wr(8'h58, 8'h01, 4'hF);
		repeat (40) @(posedge CLK);
		check(CARRIER_AMP, 8'hFF, "reserved holds");
		rd(8'h59);
		check(rdat[17], 1'b1, "reserved flag");
		// unmapped place and a write with its byte lane off
		wr(8'hF0, 8'h12, 4'hF);
		check(rsp, 2'b10, "unmapped write");
		rd(8'hF0);
		check(rsp, 2'b10, "unmapped read resp");
		check(rdat, 32'h0, "unmapped read");
		wr(8'h52, 8'h77, 4'h0);
		rd(8'h52);
		check(rdat, 32'h0, "lane off");
		// reset in the middle of a long edge
		wr(8'h51, 8'h11, 4'hF);
		wr(8'h53, 8'h1F, 4'hF);
		wr(8'h58, 8'h01, 4'hF);
		repeat (8) @(posedge CLK);
		check(EDGE_BUSY, 1'b1, "edge running");
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		check({EDGE_BUSY, CARRIER_AMP}, 9'h0FF, "busy amp in reset");
		RST_N <= 1'b1;
		rd(8'h53);
		check(rdat, `RST_COUNT_STRETCH, "count after reset");
		stop_test();
	end
endmodule : edge_shaper_test
